// ### src/lfs_pkg.sv
/*
  shared constants and carriers for the led driver fault supervisor.
  assumes a single switching-oscillator clock of 20 MHz.
*/
package lfs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned SHORT_DELAY_CYC   = 2;      // led overcurrent qualify time
  localparam int unsigned HICCUP_SKIP_CYC   = 16000;  // retry interval, switching cycles
  localparam int unsigned HICCUP_CNT_W      = 14;
  localparam int unsigned SHORT_CNT_W       = 2;
  localparam logic [1:0]  SHORT_CNT_ZERO    = 2'h0;
  localparam logic [13:0] HICCUP_CNT_ZERO   = 14'h0;
  localparam int unsigned SYNC_STAGES       = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // raw comparator levels from the analog front end
  typedef struct packed {
    logic overvoltage;       // output at or above overvoltage level
    logic overvoltageClear;  // output below level minus hysteresis
    logic ledOvercurrent;    // led_sense_pos - led_sense_neg above threshold
    logic switchOvercurrent; // switch current above switch_current_limit
    logic overTemp;          // die above 165 C
    logic overTempClear;     // die below 145 C
    logic supplyLow;         // supply_low_lockout active
    logic regulatorLow;      // internal regulator below 1.4 V
  } lfs_sense_t;

  localparam int unsigned SENSE_W = $bits(lfs_sense_t);

  // drive outputs toward the power stage
  typedef struct packed {
    logic gateDrive;         // power switch drive
    logic dimSwitchDrive;    // dimming switch drive
    logic standby;           // device held in standby
    logic compReset;         // compensation node forced to zero
  } lfs_drive_t;

  typedef enum logic [1:0] {
    LFS_TOPO_BOOST     = 2'h0,
    LFS_TOPO_BUCKBOOST = 2'h1,
    LFS_TOPO_SEPIC     = 2'h2,
    LFS_TOPO_BUCK      = 2'h3
  } lfs_topo_t;

  typedef enum logic [1:0] {
    LFS_HIC_RUN  = 2'h0,
    LFS_HIC_SKIP = 2'h1
  } lfs_hic_t;

endpackage

// ### src/lfs_sync.sv
/*
  two-flop synchroniser bank for comparator levels.
  assumes inputs are asynchronous levels; first stage read only by second.
*/
`timescale 1ns/1ps
module lfs_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstSyncN,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import lfs_pkg::*;

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule

// ### src/lfs_fault_supervisor.sv
/*
  fault supervisor for a switching led current controller: gates the
  power and dimming switch drives, standby and compensation reset, runs the
  led-short hiccup timer and drives an open-drain fault flag.
  assumes core_clk is the switching oscillator and the comparators are
  analog levels synchronised here.
*/
`timescale 1ns/1ps
module lfs_fault_supervisor (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // configuration and requests
  input  wire lfs_pkg::lfs_topo_t topology,
  input  wire logic               gateRequest,
  input  wire logic               dimRequest,
  // comparator levels
  input  wire lfs_pkg::lfs_sense_t sense,
  // power stage
  output lfs_pkg::lfs_drive_t     drive,
  // open-drain fault flag
  input  wire logic               faultFlagIn,
  output logic                    faultFlagOut,
  output logic                    faultFlagOe
);
  import lfs_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSyncN;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_reg <= 1'b0;
      rstSyncN    <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSyncN    <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  lfs_sense_t senseSync;
  logic [SENSE_W-1:0] senseSyncBits;

  lfs_sync #(
    .WIDTH (SENSE_W)
  ) u_sync (
    .core_clk (core_clk),
    .rstSyncN (rstSyncN),
    .asyncIn  (sense),
    .syncOut  (senseSyncBits)
  );

  assign senseSync = lfs_sense_t'(senseSyncBits);

  // flag faultFlagIn is only observed by the host; a shared line may be
  // pulled low by a neighbour, which must not affect this device
  logic unusedFlagIn;
  assign unusedFlagIn = faultFlagIn;

  // ----------------------------------------------------------------
  // latched fault state
  // ----------------------------------------------------------------
  logic ovLatch_reg;
  logic ovLatch_next;
  logic otLatch_reg;
  logic otLatch_next;

  always_comb begin
    ovLatch_next = ovLatch_reg;
    if (senseSync.overvoltage) begin
      ovLatch_next = 1'b1;
    end else if (senseSync.overvoltageClear) begin
      ovLatch_next = 1'b0;
    end
    otLatch_next = otLatch_reg;
    if (senseSync.overTemp) begin
      otLatch_next = 1'b1;
    end else if (senseSync.overTempClear) begin
      otLatch_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ovLatch_reg <= 1'b0;
      otLatch_reg <= 1'b0;
    end else begin
      ovLatch_reg <= ovLatch_next;
      otLatch_reg <= otLatch_next;
    end
  end

  // ----------------------------------------------------------------
  // led short hiccup
  // ----------------------------------------------------------------
  lfs_hic_t                hicState_reg;
  lfs_hic_t                hicState_next;
  logic [SHORT_CNT_W-1:0]  shortCnt_reg;
  logic [SHORT_CNT_W-1:0]  shortCnt_next;
  logic [HICCUP_CNT_W-1:0] hicCnt_reg;
  logic [HICCUP_CNT_W-1:0] hicCnt_next;
  logic                    boostMode;

  assign boostMode = (topology == LFS_TOPO_BOOST);

  always_comb begin
    hicState_next = hicState_reg;
    shortCnt_next = SHORT_CNT_ZERO;
    hicCnt_next   = hicCnt_reg;
    unique case (hicState_reg)
      LFS_HIC_RUN: begin
        // other topologies keep the short under loop regulation
        if (boostMode && senseSync.ledOvercurrent) begin
          shortCnt_next = shortCnt_reg + SHORT_CNT_W'(1);
          if (shortCnt_reg == SHORT_CNT_W'(SHORT_DELAY_CYC - 1)) begin
            hicState_next = LFS_HIC_SKIP;
            hicCnt_next   = HICCUP_CNT_ZERO;
            shortCnt_next = SHORT_CNT_ZERO;
          end
        end
      end
      LFS_HIC_SKIP: begin
        hicCnt_next = hicCnt_reg + HICCUP_CNT_W'(1);
        if (hicCnt_reg == HICCUP_CNT_W'(HICCUP_SKIP_CYC - 1)) begin
          // retry; a persisting short re-qualifies and skips again
          hicState_next = LFS_HIC_RUN;
          hicCnt_next   = HICCUP_CNT_ZERO;
        end
      end
      // unused codes fall back to regulation rather than sticking
      default: begin
        hicState_next = LFS_HIC_RUN;
        hicCnt_next   = HICCUP_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      hicState_reg <= LFS_HIC_RUN;
      shortCnt_reg <= SHORT_CNT_ZERO;
      hicCnt_reg   <= HICCUP_CNT_ZERO;
    end else begin
      hicState_reg <= hicState_next;
      shortCnt_reg <= shortCnt_next;
      hicCnt_reg   <= hicCnt_next;
    end
  end

  // ----------------------------------------------------------------
  // cycle-by-cycle current limit
  // ----------------------------------------------------------------
  // core_clk is the switching cycle, so a trip blanks the gate from the cycle after
  // detection and holds it off for as long as the synchronised switchOvercurrent stays high
  logic curLimit_reg;
  logic curLimit_next;

  always_comb begin
    curLimit_next = senseSync.switchOvercurrent;
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      curLimit_reg <= 1'b0;
    end else begin
      curLimit_reg <= curLimit_next;
    end
  end

  // ----------------------------------------------------------------
  // output drives
  // ----------------------------------------------------------------
  lfs_drive_t drive_reg;
  lfs_drive_t drive_next;
  logic       faultOe_reg;
  logic       faultOe_next;
  logic       hicSkip;
  logic       shutdown;
  logic       reported;

  assign hicSkip  = (hicState_next == LFS_HIC_SKIP);
  // next-state terms so a fresh fault reaches the pins one edge later
  assign shutdown = ovLatch_next | otLatch_next | senseSync.supplyLow
                  | senseSync.regulatorLow | hicSkip;
  assign reported = ovLatch_next | otLatch_next | senseSync.regulatorLow | hicSkip;

  always_comb begin
    drive_next.gateDrive      = gateRequest & ~shutdown & ~curLimit_next;
    drive_next.dimSwitchDrive = dimRequest & ~ovLatch_next & ~hicSkip
                              & ~senseSync.supplyLow;
    drive_next.standby        = ovLatch_next | otLatch_next | senseSync.supplyLow
                              | senseSync.regulatorLow;
    drive_next.compReset      = shutdown;
    // supply low alone leaves the flag released
    faultOe_next              = reported;
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      drive_reg   <= '0;
      faultOe_reg <= 1'b0;
    end else begin
      drive_reg   <= drive_next;
      faultOe_reg <= faultOe_next;
    end
  end

  assign drive        = drive_reg;
  assign faultFlagOe  = faultOe_reg;
  assign faultFlagOut = 1'b0;
endmodule

// ### tb/lfs_fault_supervisor_props.sv
/* checker on the fault supervisor ports.
   assumes 3-edge sense latency and a two-flop reset release. */
`timescale 1ns/1ps
module lfs_fault_supervisor_props (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rstn,
  // watched ports
  input wire lfs_pkg::lfs_topo_t  topology,
  input wire lfs_pkg::lfs_sense_t sense,
  input wire lfs_pkg::lfs_drive_t drive,
  input wire logic                faultFlagOut,
  input wire logic                faultFlagOe
);
  import lfs_pkg::*;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // six samples cover the reset release lag plus sync and output flops
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire oth = sense.overvoltage | sense.overTemp | sense.regulatorLow;
  a_ov_shut: assert property (sense.overvoltage [*6] |->
    !drive.gateDrive && !drive.dimSwitchDrive && faultFlagOe) else $error("ov drives on");
  a_ov_hold: assert property (sense.overvoltage [*6] ##1 !sense.overvoltageClear [*4] |->
    faultFlagOe && drive.standby) else $error("ov flag dropped");
  a_short_trip: assert property ($rose(sense.ledOvercurrent) ##0
    (sense.ledOvercurrent && topology == LFS_TOPO_BOOST) [*4] |-> ##[0:4]
    (!drive.dimSwitchDrive && drive.compReset && faultFlagOe)) else $error("no hiccup");
  a_topo_gate: assert property ((topology != LFS_TOPO_BOOST && !oth) [*4]
    ##0 !faultFlagOe |=> !faultFlagOe) else $error("short flag off boost");
  a_ot_trip: assert property (sense.overTemp [*6] |->
    drive.standby && faultFlagOe) else $error("ot no standby");
  a_sup_low: assert property (sense.supplyLow [*6] |->
    !drive.gateDrive && !drive.dimSwitchDrive && drive.standby && drive.compReset)
    else $error("supply_low_lockout drives on");
  a_reg_low: assert property (sense.regulatorLow [*6] |->
    !drive.gateDrive && drive.standby && faultFlagOe) else $error("reg low missed");
  a_cl_gate: assert property (sense.switchOvercurrent [*6] |-> !drive.gateDrive)
    else $error("gate on at limit");
  a_od_low: assert property (faultFlagOe |-> faultFlagOut == 1'b0)
    else $error("flag driven high");
endmodule

bind lfs_fault_supervisor lfs_fault_supervisor_props lfs_fault_supervisor_props_i (
  .core_clk(core_clk), .rstn(rstn), .topology(topology), .sense(sense),
  .drive(drive), .faultFlagOut(faultFlagOut), .faultFlagOe(faultFlagOe));

// ### tb/lfs_host_model.sv
/* host end of the open-drain fault line.
   assumes the supervisor pulls low only while faultFlagOe is high. */
`timescale 1ns/1ps
module lfs_host_model (
  // device side
  input  wire logic faultFlagOut,
  input  wire logic faultFlagOe,
  // host view
  output logic      faultLine
);
  // ----------------------------------------------------------------
  // pull-up
  // ----------------------------------------------------------------
  // a released line rises to the host supply; never left floating
  assign faultLine = faultFlagOe ? faultFlagOut : 1'b1;
endmodule

// ### tb/lfs_fault_supervisor_tb.sv
/* self-checking bench for the fault supervisor.
   assumes the host model pull-up and 3-edge sense latency. */
`timescale 1ns/1ps
module lfs_fault_supervisor_tb;
  import lfs_pkg::*;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  logic       core_clk        = 1'b0;
  logic       rstn            = 1'b0;
  lfs_topo_t  topology        = LFS_TOPO_BOOST;
  lfs_sense_t sense           = '0;
  logic       gateRequest     = 1'b1;
  logic       dimRequest      = 1'b1;
  lfs_drive_t drive;
  logic       faultLine;
  logic       faultFlagOut;
  logic       faultFlagOe;
  int         n_errors        = 0;
  int         samples_checked = 0;
  always #25 core_clk = ~core_clk;
  lfs_fault_supervisor lfs_fault_supervisor_i (.core_clk(core_clk), .rstn(rstn),
    .topology(topology), .gateRequest(gateRequest), .dimRequest(dimRequest), .sense(sense),
    .drive(drive), .faultFlagIn(faultLine), .faultFlagOut(faultFlagOut),
    .faultFlagOe(faultFlagOe));
  lfs_host_model lfs_host_model_i (.faultFlagOut(faultFlagOut),
    .faultFlagOe(faultFlagOe), .faultLine(faultLine));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic put(input logic [7:0] v);
    @(posedge core_clk);
    sense <= lfs_sense_t'(v);
  endtask
  // expected {gate, dim, standby, compReset, line}
  task automatic chk(input logic [4:0] e);
    samples_checked++;
    if ({drive, faultLine} !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t out %b exp %b", $time, {drive, faultLine}, e);
    end
  endtask
  task automatic wait_dim(input logic lv, input int lo, input int hi);
    int n = 0;
    while (drive.dimSwitchDrive !== lv && n <= hi) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    samples_checked++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("CHECK FAILED %0t dim after %0d", $time, n);
      if (n > hi) tally_and_finish();
    end
  endtask
  task automatic t_levels();
    logic [7:0] v [3] = '{8'h02, 8'h01, 8'h10};
    logic [4:0] e [3] = '{5'h07, 5'h0e, 5'h09};
    for (int i = 0; i < 3; i++) begin
      put(v[i]);
      wt(6);
      chk(e[i]);
      put(8'h00);
      wt(5);
      chk(5'h19);
    end
    $display("levels done");
  endtask
  task automatic t_latch(input logic [7:0] s, input logic [7:0] c, input logic [4:0] e);
    put(s);
    wt(6);
    chk(e);
    put(8'h00);
    wt(8);
    chk(e);
    put(c);
    wt(5);
    chk(5'h19);
    put(8'h00);
    $display("latch done");
  endtask
  task automatic t_short();
    put(8'h20);
    wait_dim(1'b0, 3, 6);
    wt(1);
    chk(5'h02);
    // one skip cycle was already spent by the check above
    wait_dim(1'b1, HICCUP_SKIP_CYC - 1, HICCUP_SKIP_CYC + 1);
    wait_dim(1'b0, 1, 8);
    put(8'h00);
    wait_dim(1'b1, HICCUP_SKIP_CYC - 2, HICCUP_SKIP_CYC + 2);
    wt(2);
    chk(5'h19);
    $display("short done");
  endtask
  task automatic t_request();
    @(posedge core_clk);
    gateRequest <= 1'b0;
    dimRequest  <= 1'b0;
    wt(2);
    chk(5'h01);
    @(posedge core_clk);
    gateRequest <= 1'b1;
    dimRequest  <= 1'b1;
    wt(2);
    chk(5'h19);
    $display("request done");
  endtask
  task automatic t_topo();
    for (int t = 1; t < 4; t++) begin
      @(posedge core_clk);
      topology <= lfs_topo_t'(t[1:0]);
      put(8'h20);
      wt(12);
      chk(5'h19);
      put(8'h00);
    end
    $display("topology done");
  endtask
  initial begin
    wt(4);
    chk(5'h01);
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    wt(8);
    chk(5'h19);
    t_request();
    t_levels();
    t_latch(8'h80, 8'h40, 5'h06);
    t_latch(8'h08, 8'h04, 5'h0e);
    t_short();
    t_topo();
    tally_and_finish();
  end
endmodule
